// ---- hdl/cpf_pkg.sv ----
// Constants and types of the configuration protection byte bank
package cpf_pkg;

  localparam int unsigned APB_AW = 24;
  localparam int unsigned IDX_W  = 22;
  localparam int unsigned PADDR_W = 14;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DBG_BOOT  = 22'h300006;
  localparam logic [IDX_W-1:0] IDX_CP_LOW    = 22'h300008;
  localparam logic [IDX_W-1:0] IDX_CP_HIGH   = 22'h300009;
  localparam logic [IDX_W-1:0] IDX_WP_LOW    = 22'h30000a;
  localparam logic [IDX_W-1:0] IDX_WP_HIGH   = 22'h30000b;
  localparam logic [IDX_W-1:0] IDX_CTRL      = 22'h300010;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 22'h300011;

  // Implemented bits and unprogrammed values
  localparam logic [7:0] DBG_BOOT_MASK  = 8'hf1;
  localparam logic [7:0] DBG_BOOT_RST   = 8'h81;
  localparam logic [7:0] CP_LOW_MASK    = 8'h03;
  localparam logic [7:0] CP_HIGH_MASK   = 8'hc0;
  localparam logic [7:0] WP_LOW_MASK    = 8'h03;
  localparam logic [7:0] WP_HIGH_MASK   = 8'he0;

  // Field positions
  localparam int unsigned POS_STACK_RST   = 0;
  localparam int unsigned POS_BOOT_SEL_LO = 4;
  localparam int unsigned POS_BOOT_SEL_HI = 5;
  localparam int unsigned POS_INSTR_EXT   = 6;
  localparam int unsigned POS_DEBUG_PIN   = 7;
  localparam int unsigned POS_GUARD_B0    = 0;
  localparam int unsigned POS_GUARD_B1    = 1;
  localparam int unsigned POS_GUARD_CFG   = 5;
  localparam int unsigned POS_GUARD_BOOT  = 6;
  localparam int unsigned POS_GUARD_EE    = 7;
  localparam int unsigned POS_CTRL_ERASE  = 0;

  // Program memory layout, byte addresses
  localparam logic [PADDR_W-1:0] BOOT_END_256W = 14'h0200;
  localparam logic [PADDR_W-1:0] BOOT_END_512W = 14'h0400;
  localparam logic [PADDR_W-1:0] BOOT_END_1KW  = 14'h0800;
  localparam logic [PADDR_W-1:0] BLOCK1_START  = 14'h1000;

  typedef enum logic [1:0] {
    CPF_TGT_PROG   = 2'b00,
    CPF_TGT_EEPROM = 2'b01,
    CPF_TGT_CONFIG = 2'b10
  } cpf_target_e;

  typedef enum logic [1:0] {
    CPF_REG_BOOT   = 2'b00,
    CPF_REG_BLOCK0 = 2'b01,
    CPF_REG_BLOCK1 = 2'b10
  } cpf_region_e;

  typedef struct packed {
    logic [7:0] dbg_boot;
    logic [7:0] cp_low;
    logic [7:0] cp_high;
    logic [7:0] wp_low;
    logic [7:0] wp_high;
  } cpf_bank_s;

  typedef struct packed {
    logic               valid;
    logic               write;
    logic               external;
    cpf_target_e        target;
    logic [PADDR_W-1:0] addr;
  } cpf_acc_s;

endpackage

// ---- hdl/cpf_region.sv ----
// Program memory region decoder with selectable boot block length
module cpf_region
  import cpf_pkg::*;
(
  input  wire logic [PADDR_W-1:0] addr,
  input  wire logic [1:0]         boot_size_sel,
  input  wire logic               large_part,
  output cpf_region_e             region
);
  logic [PADDR_W-1:0] boot_end;

  always_comb
  begin
    // Small part caps every nonzero select at 512 words
    unique case (boot_size_sel)
      2'b00:   boot_end = BOOT_END_256W;
      2'b01:   boot_end = BOOT_END_512W;
      default: boot_end = large_part ? BOOT_END_1KW : BOOT_END_512W;
    endcase
    if (addr < boot_end)
      region = CPF_REG_BOOT;
    else if (addr < BLOCK1_START)
      region = CPF_REG_BLOCK0;
    else
      region = CPF_REG_BLOCK1;
  end
endmodule

// ---- hdl/cpf_fuses.sv ----
// Configuration protection byte bank with APB access and access gating
module cpf_fuses
  import cpf_pkg::*;
#(
  parameter bit LARGE_PART = 1'b1
)
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              prog_mode_pin,
  input  cpf_pkg::cpf_acc_s      acc_req,
  output logic                   acc_grant,
  output logic                   acc_deny,
  input  wire logic              stack_fault,
  output logic                   stack_reset,
  output logic                   debugger_pin_enable,
  output logic                   instruction_extension_enable,
  output logic [1:0]             boot_size_sel
);
  cpf_bank_s          bank_r;
  logic               prog_meta_r;
  logic               prog_mode_r;
  logic [31:0]        prdata_r;
  logic               pready_r;
  logic               pslverr_r;
  logic               grant_r;
  logic               deny_r;
  logic               stack_reset_r;
  logic               last_deny_r;
  logic [IDX_W-1:0]   idx;
  logic               setup;
  logic               commit;
  logic               mapped;
  logic               wr_ok;
  logic [31:0]        rd_nxt;
  cpf_region_e        region;
  logic               read_guard;
  logic               write_guard;
  logic               denied;

  assign idx    = paddr[APB_AW-1:2];
  assign setup  = psel && !penable;
  assign commit = psel && penable && pready_r;

  // Pin crosses two flops before use
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prog_meta_r <= 1'b0;
      prog_mode_r <= 1'b0;
    end
    else
    begin
      prog_meta_r <= prog_mode_pin;
      prog_mode_r <= prog_meta_r;
    end
  end

  always_comb
  begin
    mapped = 1'b1;
    rd_nxt = 32'h0000_0000;
    // Only implemented bits are stored; masking keeps the rest zero
    unique case (idx)
      IDX_DBG_BOOT: rd_nxt[7:0] = bank_r.dbg_boot & DBG_BOOT_MASK;
      IDX_CP_LOW:   rd_nxt[7:0] = bank_r.cp_low & CP_LOW_MASK;
      IDX_CP_HIGH:  rd_nxt[7:0] = bank_r.cp_high & CP_HIGH_MASK;
      IDX_WP_LOW:   rd_nxt[7:0] = bank_r.wp_low & WP_LOW_MASK;
      IDX_WP_HIGH:  rd_nxt[7:0] = bank_r.wp_high & WP_HIGH_MASK;
      IDX_CTRL:     rd_nxt      = 32'h0000_0000;
      IDX_STATUS:   rd_nxt[1:0] = {last_deny_r, prog_mode_r};
      default:      mapped      = 1'b0;
    endcase
  end

  // Outside program mode a cleared config guard freezes the bank
  always_comb
  begin
    wr_ok = mapped && (idx != IDX_STATUS);
    if (!prog_mode_r && !bank_r.wp_high[POS_GUARD_CFG])
      wr_ok = 1'b0;
    if (!prog_mode_r && idx == IDX_CTRL)
      wr_ok = 1'b0;
  end

  // Register side answers one cycle after setup
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= setup;
      prdata_r  <= (setup && !pwrite) ? rd_nxt : 32'h0000_0000;
      pslverr_r <= setup && (pwrite ? !wr_ok : !mapped);
    end
  end

  // Bank: erase restores the unprogrammed pattern; dbg_boot is overwritten, other bytes clear only
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bank_r.dbg_boot <= DBG_BOOT_RST;
      bank_r.cp_low   <= CP_LOW_MASK;
      bank_r.cp_high  <= CP_HIGH_MASK;
      bank_r.wp_low   <= WP_LOW_MASK;
      bank_r.wp_high  <= WP_HIGH_MASK;
    end
    else if (commit && pwrite && !pslverr_r)
    begin
      unique case (idx)
        IDX_DBG_BOOT:
          bank_r.dbg_boot <= pwdata[7:0] & DBG_BOOT_MASK;
        IDX_CP_LOW:
          bank_r.cp_low <= bank_r.cp_low & pwdata[7:0];
        IDX_CP_HIGH:
          bank_r.cp_high <= bank_r.cp_high & pwdata[7:0];
        IDX_WP_LOW:
          bank_r.wp_low <= bank_r.wp_low & pwdata[7:0];
        IDX_WP_HIGH:
        begin
          bank_r.wp_high[POS_GUARD_EE] <=
            bank_r.wp_high[POS_GUARD_EE] & pwdata[POS_GUARD_EE];
          bank_r.wp_high[POS_GUARD_BOOT] <=
            bank_r.wp_high[POS_GUARD_BOOT] & pwdata[POS_GUARD_BOOT];
          if (prog_mode_r)
            bank_r.wp_high[POS_GUARD_CFG] <=
              bank_r.wp_high[POS_GUARD_CFG] & pwdata[POS_GUARD_CFG];
        end
        IDX_CTRL:
          if (pwdata[POS_CTRL_ERASE])
          begin
            bank_r.dbg_boot <= DBG_BOOT_RST;
            bank_r.cp_low   <= CP_LOW_MASK;
            bank_r.cp_high  <= CP_HIGH_MASK;
            bank_r.wp_low   <= WP_LOW_MASK;
            bank_r.wp_high  <= WP_HIGH_MASK;
          end
        default:
          bank_r <= bank_r;
      endcase
    end
  end

  cpf_region u_region (
    .addr          (acc_req.addr),
    .boot_size_sel ({bank_r.dbg_boot[POS_BOOT_SEL_HI],
                     bank_r.dbg_boot[POS_BOOT_SEL_LO]}),
    .large_part    (LARGE_PART),
    .region        (region)
  );

  always_comb
  begin
    read_guard  = 1'b1;
    write_guard = 1'b1;
    unique case (acc_req.target)
      CPF_TGT_PROG:
        unique case (region)
          CPF_REG_BOOT:
          begin
            read_guard  = bank_r.cp_high[POS_GUARD_BOOT];
            write_guard = bank_r.wp_high[POS_GUARD_BOOT];
          end
          CPF_REG_BLOCK0:
          begin
            read_guard  = bank_r.cp_low[POS_GUARD_B0];
            write_guard = bank_r.wp_low[POS_GUARD_B0];
          end
          default:
          begin
            read_guard  = bank_r.cp_low[POS_GUARD_B1];
            write_guard = bank_r.wp_low[POS_GUARD_B1];
          end
        endcase
      CPF_TGT_EEPROM:
      begin
        read_guard  = bank_r.cp_high[POS_GUARD_EE];
        write_guard = bank_r.wp_high[POS_GUARD_EE];
      end
      CPF_TGT_CONFIG:
        write_guard = bank_r.wp_high[POS_GUARD_CFG];
      default:
      begin
        read_guard  = 1'b0;
        write_guard = 1'b0;
      end
    endcase
    // Code guard only blocks reads from outside the protected area
    denied = acc_req.write ? !write_guard
                           : (acc_req.external && !read_guard);
  end

  // Verdict registered one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      grant_r     <= 1'b0;
      deny_r      <= 1'b0;
      last_deny_r <= 1'b0;
    end
    else
    begin
      grant_r <= acc_req.valid && !denied;
      deny_r  <= acc_req.valid && denied;
      if (acc_req.valid)
        last_deny_r <= denied;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      stack_reset_r <= 1'b0;
    else
      stack_reset_r <= stack_fault && bank_r.dbg_boot[POS_STACK_RST];
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign acc_grant   = grant_r;
  assign acc_deny    = deny_r;
  assign stack_reset = stack_reset_r;
  assign debugger_pin_enable          = bank_r.dbg_boot[POS_DEBUG_PIN];
  assign instruction_extension_enable = bank_r.dbg_boot[POS_INSTR_EXT];
  assign boot_size_sel = {bank_r.dbg_boot[POS_BOOT_SEL_HI],
                          bank_r.dbg_boot[POS_BOOT_SEL_LO]};
endmodule

// ---- test/cpf_fuses_sva.sv ----
// Port-level assertions for the protection byte bank
module cpf_fuses_sva
  import cpf_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input cpf_pkg::cpf_acc_s      acc_req,
  input wire logic              acc_grant,
  input wire logic              acc_deny,
  input wire logic              stack_fault,
  input wire logic              stack_reset,
  input wire logic              debugger_pin_enable,
  input wire logic              instruction_extension_enable,
  input wire logic [1:0]        boot_size_sel
);
  logic wrote_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Any write may clear guards, so blank checks stop at the first one
  always_ff @(posedge mclk)
    if (rst)
      wrote_r <= 1'b0;
    else if (psel && penable && pwrite && pready)
      wrote_r <= 1'b1;
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_apb_answer; s_setup |=> s_answer; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_cpl_bits;
    pready && !pwrite && paddr == 24'hc00020 |-> prdata[31:2] == 30'h0;
  endproperty
  a_cpl_bits: assert property (p_cpl_bits) else $error("cp low bits");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_acc; acc_req.valid |=> acc_grant != acc_deny; endproperty
  a_acc: assert property (p_acc) else $error("access verdict");
  property p_acc_idle; !acc_req.valid |=> !acc_grant && !acc_deny; endproperty
  a_acc_idle: assert property (p_acc_idle) else $error("spurious verdict");
  property p_local_read;
    acc_req.valid && !acc_req.write && !acc_req.external |=> acc_grant;
  endproperty
  a_local_read: assert property (p_local_read) else $error("local read");
  property p_blank; !wrote_r && acc_req.valid |=> acc_grant; endproperty
  a_blank: assert property (p_blank) else $error("blank bank denied");
  property p_stack; stack_reset |-> $past(stack_fault); endproperty
  a_stack: assert property (p_stack) else $error("stack reset cause");
  property p_rst_levels;
    disable iff (1'b0) rst |=> !pready && !acc_grant && debugger_pin_enable
      && !instruction_extension_enable && boot_size_sel == 2'b00;
  endproperty
  a_rst_levels: assert property (p_rst_levels) else $error("reset state");
endmodule

// ---- test/cpf_prog_model.sv ----
// Programmer and memory access model facing the bank
module cpf_prog_model
  import cpf_pkg::*;
(
  input  wire logic mclk,
  input  wire logic acc_grant,
  input  wire logic acc_deny,
  output logic      prog_mode_pin,
  output cpf_acc_s  acc_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    prog_mode_pin = 1'b0;
    acc_req = '0;
  end
  // Waits out the two-flop synchroniser
  task automatic set_prog(input logic on);
    @(posedge mclk);
    prog_mode_pin <= on;
    repeat (4) @(posedge mclk);
  endtask
  task automatic acc(input logic w, input logic x, input cpf_target_e t,
                     input logic [PADDR_W-1:0] a, output logic [1:0] gd);
    @(posedge mclk);
    acc_req <= '{1'b1, w, x, t, a};
    @(posedge mclk);
    acc_req <= '{1'b0, ~w, ~x, t, ~a};
    @(posedge mclk);
    gd = {acc_grant, acc_deny};
  endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the protection byte bank
module tb_top;
  import cpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] A_DBG = {IDX_DBG_BOOT, 2'b00};
  localparam logic [23:0] A_CPL = {IDX_CP_LOW, 2'b00};
  localparam logic [23:0] A_CPH = {IDX_CP_HIGH, 2'b00};
  localparam logic [23:0] A_WPL = {IDX_WP_LOW, 2'b00};
  localparam logic [23:0] A_WPH = {IDX_WP_HIGH, 2'b00};
  localparam logic [23:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [23:0] A_STS = {IDX_STATUS, 2'b00};
  logic              mclk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic              prog_mode_pin, acc_grant, acc_deny, stack_fault;
  logic              stack_reset, debugger_pin_enable;
  logic              instruction_extension_enable;
  logic [1:0]        boot_size_sel, gd;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, q;
  cpf_acc_s          acc_req;
  int                n_errors = 0;
  int                samples_checked = 0;
  cpf_fuses u_dut (.*);
  cpf_prog_model u_prog (.*);
  task automatic tally_and_finish(input bit to);
    if (to)
      $display("[ERR] %0t wait ran out", $time);
    n_errors += to;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [23:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
      tally_and_finish(1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] wd, logic xe);
    apb(1'b1, a, wd);
    chk(e, xe);
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic ac(logic w, logic x, cpf_target_e t, logic [13:0] a, logic g);
    u_prog.acc(w, x, t, a, gd);
    chk(gd, {g, ~g});
  endtask
  task automatic pulse_fault(input logic x);
    @(posedge mclk);
    stack_fault <= 1'b1;
    @(posedge mclk);
    stack_fault <= 1'b0;
    @(posedge mclk);
    chk(stack_reset, x);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    {rst, psel, penable, pwrite, stack_fault} = 5'b10000;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    ac(1'b1, 1'b1, CPF_TGT_PROG, 14'h0800, 1'b1);
    rd(A_DBG, 32'h81);
    rd(A_CPL, 32'h03);
    rd(A_CPH, 32'hc0);
    rd(A_WPL, 32'h03);
    rd(A_WPH, 32'he0);
    $display("test blank_bank done");
    wr(A_CPL, 32'hff, 1'b0);
    rd(A_CPL, 32'h03);
    wr(A_CPL, 32'h02, 1'b0);
    wr(A_CPL, 32'h03, 1'b0);
    rd(A_CPL, 32'h02);
    ac(1'b0, 1'b1, CPF_TGT_PROG, 14'h0800, 1'b0);
    ac(1'b0, 1'b1, CPF_TGT_PROG, 14'h2000, 1'b1);
    wr(A_CPH, 32'h40, 1'b0);
    ac(1'b0, 1'b1, CPF_TGT_EEPROM, 14'h0000, 1'b0);
    ac(1'b0, 1'b1, CPF_TGT_PROG, 14'h0010, 1'b1);
    wr(A_CPH, 32'h00, 1'b0);
    ac(1'b0, 1'b1, CPF_TGT_PROG, 14'h0010, 1'b0);
    $display("test read_guard done");
    wr(A_WPL, 32'h01, 1'b0);
    ac(1'b1, 1'b0, CPF_TGT_PROG, 14'h2000, 1'b0);
    wr(A_WPH, 32'ha0, 1'b0);
    ac(1'b1, 1'b0, CPF_TGT_PROG, 14'h0010, 1'b0);
    ac(1'b1, 1'b0, CPF_TGT_EEPROM, 14'h0000, 1'b1);
    ac(1'b1, 1'b0, CPF_TGT_PROG, 14'h0300, 1'b1);
    wr(A_DBG, 32'h91, 1'b0);
    ac(1'b1, 1'b0, CPF_TGT_PROG, 14'h0300, 1'b0);
    pulse_fault(1'b1);
    chk({debugger_pin_enable, instruction_extension_enable, boot_size_sel},
        4'b1001);
    wr(A_DBG, 32'h90, 1'b0);
    pulse_fault(1'b0);
    wr(A_WPL, 32'h00, 1'b0);
    ac(1'b1, 1'b0, CPF_TGT_PROG, 14'h0800, 1'b0);
    $display("test write_guard done");
    wr(A_WPH, 32'h40, 1'b0);
    rd(A_WPH, 32'h20);
    ac(1'b1, 1'b0, CPF_TGT_EEPROM, 14'h0000, 1'b0);
    u_prog.set_prog(1'b1);
    wr(A_WPH, 32'h00, 1'b0);
    rd(A_WPH, 32'h00);
    u_prog.set_prog(1'b0);
    wr(A_DBG, 32'h81, 1'b1);
    rd(A_DBG, 32'h90);
    ac(1'b1, 1'b0, CPF_TGT_CONFIG, 14'h0000, 1'b0);
    apb(1'b0, 24'hc00000, 32'h0);
    chk(e, 1'b1);
    $display("test config_lock done");
    u_prog.set_prog(1'b1);
    rd(A_STS, 32'h03);
    wr(A_STS, 32'h00, 1'b1);
    wr(A_CTL, 32'h01, 1'b0);
    rd(A_DBG, 32'h81);
    rd(A_WPH, 32'he0);
    rd(A_CPH, 32'hc0);
    $display("test erase done");
    tally_and_finish(1'b0);
  end
endmodule
bind cpf_fuses cpf_fuses_sva u_sva (.*);
